/* design/bscu_unit.v */
// branch and skip condition unit: jump and skip decisions
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "bscu_consts.vh"

module bscu_unit
(
    input  wire        mclk_i,
    input  wire        rst_i,
    input  wire        issue_i,
    input  wire [5:0]  func_i,
    input  wire [5:0]  minor_i,
    input  wire [5:0]  k_i,
    input  wire [14:0] y_i,
    input  wire [17:0] operand_i,
    input  wire [17:0] lower_accumulator_i,
    input  wire [17:0] upper_accumulator_i,
    input  wire [17:0] b_i,
    input  wire [15:0] in_active_i,
    input  wire [15:0] out_active_i,
    input  wire [15:0] ef_active_i,
    input  wire [4:0]  skip_key_i,
    input  wire [1:0]  addr_i,
    input  wire [17:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [17:0] rdata_o,
    output reg         busy_o,
    output reg         done_o,
    output reg         jump_o,
    output reg         skip_o,
    output reg  [14:0] target_o,
    output reg         b_we_o,
    output reg  [17:0] b_o
);

// ==========================================================
// local constants
localparam ST_IDLE = 1'b0;
localparam ST_EXEC = 1'b1;
// load values are whole numbers; cut to the counter width on purpose
localparam integer N_JUMP  = `BSCU_CYC_JUMP - 1;
localparam integer N_CJUMP = `BSCU_CYC_CJUMP - 1;
localparam integer N_SKIP  = `BSCU_CYC_SKIP - 1;
localparam integer N_NOSKP = `BSCU_CYC_NOSKP - 1;
localparam [6:0] LD_JUMP  = N_JUMP[6:0];
localparam [6:0] LD_CJUMP = N_CJUMP[6:0];
localparam [6:0] LD_SKIP  = N_SKIP[6:0];
localparam [6:0] LD_NOSKP = N_NOSKP[6:0];
localparam [6:0] LD_ONE   = 7'h00;

// ==========================================================
// state
reg         state_q;
reg  [6:0]  cnt_q;
reg         cs_q;
reg         eq_q;
reg         lt_q;
reg  [4:0]  kmask_q;
reg  [4:0]  key_s1_q;
reg  [4:0]  key_s2_q;
reg         jump_q;
reg         skip_q;
reg  [14:0] tgt_q;
reg         bwe_q;
reg  [17:0] bval_q;
reg         last_jump_q;
reg         last_skip_q;

// ==========================================================
// console keys come from a panel: two flops first
always @(posedge mclk_i)
begin
    if (rst_i)
    begin
        key_s1_q <= 5'h0_0;
        key_s2_q <= 5'h0_0;
    end
    else
    begin
        key_s1_q <= skip_key_i;
        key_s2_q <= key_s1_q;
    end
end

// ==========================================================
// instruction class decode
wire is_jmp = issue_i && (func_i[5:3] == `BSCU_FN_JMP_HI);
wire is_cjp = issue_i && (func_i == `BSCU_FN_CJUMP);
wire is_io  = issue_i && (func_i == `BSCU_FN_IO);
wire is_cmp = issue_i && ((func_i == `BSCU_FN_CMP)
                       || (func_i == `BSCU_FN_CMPB)
                       || (func_i == `BSCU_FN_CMPM)
                       || (func_i == `BSCU_FN_CMPBM));
wire take   = (state_q == ST_IDLE);

// ==========================================================
// compare: operand masked by upper half for 06 and 07
wire [17:0] m_val = func_i[2] ?
                    (operand_i & upper_accumulator_i)
                    : operand_i;
wire [18:0] al_tc;
wire [18:0] m_tc;

// the 19th bit keeps the compare free of wraparound at the ends
bscu_oc_conv
#(
    .W (18)
)
u_al_conv
(
    .x_i (lower_accumulator_i),
    .v_o (al_tc)
);

bscu_oc_conv
#(
    .W (18)
)
u_m_conv
(
    .x_i (m_val),
    .v_o (m_tc)
);

// equal and less-than stages from the aligned values
wire        c_eq  = (al_tc == m_tc);
wire        c_lt  = ($signed(al_tc) < $signed(m_tc));

// ==========================================================
// accumulator tests: only +0 is zero, sign bit decides sign
wire au_zero = (upper_accumulator_i == 18'h0_0000);
wire al_zero = (lower_accumulator_i == 18'h0_0000);
wire au_neg  = upper_accumulator_i[17];
wire al_neg  = lower_accumulator_i[17];

// ==========================================================
// counting jump: ones complement decrement of b
wire        b_nz   = (b_i != 18'h0_0000);
wire [18:0] b_oc;

bscu_oc_conv
#(
    .W (18)
)
u_b_conv
(
    .x_i (b_i),
    .v_o (b_oc)
);

// one below the value; -0 lands on -1, never on a second zero
wire [18:0] b_tc   = b_oc - 19'h0_0001;
wire [17:0] b_dec  = b_tc[18] ?
                     (b_tc[17:0] - 18'h0_0001) : b_tc[17:0];

// ==========================================================
// channel activity and console key selection
wire [3:0] ch     = k_i[3:0];
wire       key_hit = (|(k_i[4:0] & key_s2_q & kmask_q))
                     || k_i[5];

// ==========================================================
// jump decision for codes 60 to 67
reg jmp_cond;
always @*
begin
    jmp_cond = 1'b0;
    case (func_i[2:0])
        3'h0: jmp_cond = cs_q ? eq_q : au_zero;
        3'h1: jmp_cond = cs_q ? eq_q : al_zero;
        3'h2: jmp_cond = cs_q ? !eq_q : !au_zero;
        3'h3: jmp_cond = cs_q ? !eq_q : !al_zero;
        3'h4: jmp_cond = cs_q ? !lt_q : !au_neg;
        3'h5: jmp_cond = cs_q ? !lt_q : !al_neg;
        3'h6: jmp_cond = cs_q ? lt_q : au_neg;
        default: jmp_cond = cs_q ? lt_q : al_neg;
    endcase
end

// ==========================================================
// skip decision for the idle and key skips
reg skp_cond;
reg skp_known;
always @*
begin
    skp_cond  = 1'b0;
    skp_known = 1'b1;
    if (minor_i == `BSCU_MN_IN_IDLE)
        skp_cond = !in_active_i[ch];
    else if (minor_i == `BSCU_MN_OUT_IDLE)
        skp_cond = !out_active_i[ch];
    else if (minor_i == `BSCU_MN_EF_IDLE)
        skp_cond = !ef_active_i[ch];
    else if (minor_i == `BSCU_MN_KEY)
        skp_cond = key_hit;
    else
        skp_known = 1'b0;
end

// ==========================================================
// result and execution time for one accepted instruction
reg        r_jump;
reg        r_skip;
reg        r_bwe;
reg [17:0] r_bval;
reg [6:0]  r_load;
always @*
begin
    r_jump = 1'b0;
    r_skip = 1'b0;
    r_bwe  = 1'b0;
    r_bval = b_i;
    r_load = LD_ONE;
    if (is_jmp)
    begin
        r_jump = jmp_cond;
        r_load = LD_JUMP;
    end
    else if (is_cjp)
    begin
        // b left alone when zero, so no write back
        r_jump = b_nz;
        r_bwe  = b_nz;
        r_bval = b_dec;
        r_load = LD_CJUMP;
    end
    else if (is_io && skp_known)
    begin
        r_skip = skp_cond;
        r_load = skp_cond ? LD_SKIP : LD_NOSKP;
    end
end

// ==========================================================
// sequencer: hold the result until the time has run out
always @(posedge mclk_i)
begin
    if (rst_i)
    begin
        state_q <= ST_IDLE;
        cnt_q   <= 7'h00;
        jump_q  <= 1'b0;
        skip_q  <= 1'b0;
        tgt_q   <= 15'h0000;
        bwe_q   <= 1'b0;
        bval_q  <= 18'h0_0000;
    end
    else
    begin
        case (state_q)
            ST_IDLE:
            begin
                if (issue_i)
                begin
                    state_q <= ST_EXEC;
                    cnt_q   <= r_load;
                    jump_q  <= r_jump;
                    skip_q  <= r_skip;
                    tgt_q   <= y_i;
                    bwe_q   <= r_bwe;
                    bval_q  <= r_bval;
                end
            end
            default:
            begin
                if (cnt_q == 7'h00)
                    state_q <= ST_IDLE;
                else
                    cnt_q <= cnt_q - 7'h01;
            end
        endcase
    end
end

// ==========================================================
// comparison designator; a compare load beats a clear
always @(posedge mclk_i)
begin
    if (rst_i)
    begin
        cs_q <= 1'b0;
        eq_q <= 1'b0;
        lt_q <= 1'b0;
    end
    else if (take && is_cmp)
    begin
        cs_q <= 1'b1;
        eq_q <= c_eq;
        lt_q <= c_lt;
    end
    else if (take && issue_i && !is_jmp)
        cs_q <= 1'b0;
    else if (wr_i && (addr_i == `BSCU_REG_CTRL)
             && wdata_i[`BSCU_CTRL_CLR])
        cs_q <= 1'b0;
end

// ==========================================================
// outputs: results stand for the one done cycle only
wire fin = (state_q == ST_EXEC) && (cnt_q == 7'h00);
always @(posedge mclk_i)
begin
    if (rst_i)
    begin
        busy_o      <= 1'b0;
        done_o      <= 1'b0;
        jump_o      <= 1'b0;
        skip_o      <= 1'b0;
        target_o    <= 15'h0000;
        b_we_o      <= 1'b0;
        b_o         <= 18'h0_0000;
        last_jump_q <= 1'b0;
        last_skip_q <= 1'b0;
    end
    else
    begin
        busy_o   <= (take && issue_i) || (state_q == ST_EXEC && !fin);
        done_o   <= fin;
        jump_o   <= fin && jump_q;
        skip_o   <= fin && skip_q;
        target_o <= fin ? tgt_q : 15'h0000;
        b_we_o   <= fin && bwe_q;
        b_o      <= fin ? bval_q : 18'h0_0000;
        if (fin)
        begin
            last_jump_q <= jump_q;
            last_skip_q <= skip_q;
        end
    end
end

// ==========================================================
// register port: key mask write, read data one cycle later
always @(posedge mclk_i)
begin
    if (rst_i)
    begin
        kmask_q <= `BSCU_KMASK_RST;
        rdata_o <= 18'h0_0000;
    end
    else
    begin
        if (wr_i && (addr_i == `BSCU_REG_KMASK))
            kmask_q <= wdata_i[4:0];
        rdata_o <= 18'h0_0000;
        if (rd_i)
        begin
            if (addr_i == `BSCU_REG_STAT)
            begin
                rdata_o[`BSCU_ST_CMP]  <= cs_q;
                rdata_o[`BSCU_ST_EQ]   <= eq_q;
                rdata_o[`BSCU_ST_LT]   <= lt_q;
                rdata_o[`BSCU_ST_BUSY] <= (state_q == ST_EXEC);
                rdata_o[`BSCU_ST_JUMP] <= last_jump_q;
                rdata_o[`BSCU_ST_SKIP] <= last_skip_q;
                rdata_o[`BSCU_ST_KEY_LO +: 5] <= key_s2_q;
            end
            else if (addr_i == `BSCU_REG_KMASK)
                rdata_o[4:0] <= kmask_q;
        end
    end
end

endmodule

// ==========================================================
// ones complement word to a two's complement value one bit
// wider; negative zero folds onto plain zero
module bscu_oc_conv
#(
    parameter W = 18
)
(
    input  wire [W-1:0] x_i,
    output wire [W:0]   v_o
);

wire [W:0] ext_w = {x_i[W-1], x_i};
wire [W:0] one_w = {{W{1'b0}}, 1'b1};

// a negative word sits one below its two's complement twin
assign v_o = x_i[W-1] ? (ext_w + one_w) : ext_w;

endmodule
`default_nettype wire

/* design/bscu_consts.vh */
// constants for the branch and skip condition unit
//
// Notes on behaviour
// - three-stage designator steers governed jumps
// - operand masked by upper half for 06/07
// - upper accumulator only masks, never compared
// - 60: upper zero, or compare and equal
// - 61: lower zero, or compare and equal
// - 62: upper nonzero, or compare, not equal
// - 63: lower nonzero, or compare, not equal
// - 64: upper positive, or compare, not less
// - 65: lower positive, or compare, not less
// - 66: upper negative, or compare and less
// - 67: lower negative, or compare and less
// - taken jump loads y; each 4 us
// - counting jump: B nonzero, decrement, jump
// - satisfied skip bypasses exactly one instruction
// - skip 6 us, no skip 4.67 us (code: no skip loads 46 cycles of 100 ns, 4.6 us)
// - 50 21 skips on input idle
// - 50 22 skips on output idle
// - 50 23 skips on extfunc idle
// - 18-bit ones complement, two zeros
`ifndef BSCU_CONSTS_VH
`define BSCU_CONSTS_VH

// ==========================================================
// function and minor codes (6-bit, jump group as its top 3 bits; octal in comments)
`define BSCU_FN_JMP_HI   3'h6
`define BSCU_FN_CJUMP    6'h38
`define BSCU_FN_IO       6'h28
`define BSCU_FN_CMP      6'h02
`define BSCU_FN_CMPB     6'h03
`define BSCU_FN_CMPM     6'h06
`define BSCU_FN_CMPBM    6'h07
`define BSCU_MN_IN_IDLE  6'h11
`define BSCU_MN_OUT_IDLE 6'h12
`define BSCU_MN_EF_IDLE  6'h13
`define BSCU_MN_KEY      6'h28

// ==========================================================
// register map and fields
`define BSCU_REG_STAT    2'h0
`define BSCU_REG_KMASK   2'h1
`define BSCU_REG_CTRL    2'h2
`define BSCU_KMASK_RST   5'h1f
`define BSCU_ST_CMP      0
`define BSCU_ST_EQ       1
`define BSCU_ST_LT       2
`define BSCU_ST_BUSY     3
`define BSCU_ST_JUMP     4
`define BSCU_ST_SKIP     5
`define BSCU_ST_KEY_LO   6
`define BSCU_CTRL_CLR    0

// ==========================================================
// timing, in ns and in 100 ns cycles
`define BSCU_CLK_NS      100
`define BSCU_T_JUMP_NS   4000
`define BSCU_T_CJUMP_NS  12000
`define BSCU_T_SKIP_NS   6000
`define BSCU_T_NOSKP_NS  4670
`define BSCU_CYC_JUMP    (`BSCU_T_JUMP_NS / `BSCU_CLK_NS)
`define BSCU_CYC_CJUMP   (`BSCU_T_CJUMP_NS / `BSCU_CLK_NS)
`define BSCU_CYC_SKIP    (`BSCU_T_SKIP_NS / `BSCU_CLK_NS)
`define BSCU_CYC_NOSKP   (`BSCU_T_NOSKP_NS / `BSCU_CLK_NS)

`endif

/* test/bscu_unit_sva.sv */
// assertion checker for the branch and skip condition unit
`timescale 1ns/10ps
`default_nettype none
// ====
// port checker
module bscu_chk
(
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        issue_i,
    input wire logic [5:0]  func_i,
    input wire logic [5:0]  minor_i,
    input wire logic [5:0]  k_i,
    input wire logic        busy_o,
    input wire logic        done_o,
    input wire logic        jump_o,
    input wire logic        skip_o,
    input wire logic [14:0] target_o,
    input wire logic        b_we_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // busy low means idle, so an offered instruction is taken
    wire go = issue_i && !busy_o;
    wire key = go && func_i == 6'h28 && minor_i == 6'h28;
    property p_cj_time;
        go && func_i[5:3] == 3'h6 |-> ##41 (done_o && !skip_o);
    endproperty
    a_cj_time: assert property (p_cj_time) else $error("jump time");
    property p_cj_busy;
        go && func_i[5:3] == 3'h6 |=> busy_o [*8];
    endproperty
    a_cj_busy: assert property (p_cj_busy) else $error("jump busy");
    property p_bj_time;
        go && func_i == 6'h38 |-> ##121 done_o;
    endproperty
    a_bj_time: assert property (p_bj_time) else $error("count time");
    property p_key_all;
        key && k_i[5] |-> ##61 (done_o && skip_o);
    endproperty
    a_key_all: assert property (p_key_all) else $error("key skip");
    property p_noskip;
        key && k_i == 6'h00 |-> ##47 (done_o && !skip_o);
    endproperty
    a_noskip: assert property (p_noskip) else $error("no skip time");
    property p_pulse;
        done_o |=> !done_o && (busy_o == $past(issue_i));
    endproperty
    a_pulse: assert property (p_pulse) else $error("done pulse");
    property p_flow;
        (jump_o || skip_o) |-> done_o && !(jump_o && skip_o);
    endproperty
    a_flow: assert property (p_flow) else $error("flow pulse");
    property p_idle;
        !done_o |-> target_o == 15'h0 && !b_we_o;
    endproperty
    a_idle: assert property (p_idle) else $error("idle outputs");
    property p_bwe;
        b_we_o |-> jump_o;
    endproperty
    a_bwe: assert property (p_bwe) else $error("b write");
    c_jump: cover property (jump_o);
    c_skip: cover property (skip_o);
    c_bwe: cover property (b_we_o);
endmodule
bind bscu_unit bscu_chk u_chk
(
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .issue_i  (issue_i),
    .func_i   (func_i),
    .minor_i  (minor_i),
    .k_i      (k_i),
    .busy_o   (busy_o),
    .done_o   (done_o),
    .jump_o   (jump_o),
    .skip_o   (skip_o),
    .target_o (target_o),
    .b_we_o   (b_we_o)
);
`default_nettype wire

/* test/bscu_unit_tb.sv */
// self-checking bench for the branch and skip condition unit
`timescale 1ns/10ps
`default_nettype none
module bscu_unit_tb;
    logic        mclk_i = 0, rst_i = 1, issue_i = 0, wr_i = 0, rd_i = 0;
    logic [5:0]  func_i = 0, minor_i = 0, k_i = 0;
    logic [14:0] y_i = 15'h2a5c, target_o;
    logic [17:0] operand_i = 0, lower_accumulator_i = 0, upper_accumulator_i = 0;
    logic [17:0] b_i = 0, wdata_i = 0, rdata_o, b_o, c_b;
    logic [15:0] in_active_i = 0, out_active_i = 0, ef_active_i = 0;
    logic [4:0]  skip_key_i = 5'h04;
    logic [1:0]  addr_i = 0;
    logic        busy_o, done_o, jump_o, skip_o, b_we_o, c_we;
    int          error_cnt = 0, tests_run = 0;
    // row: code, upper, lower, expected jump (designator clear)
    logic [42:0] rows [12] = '{
        {6'h30, 18'h0, 18'h1, 1'b1}, {6'h30, 18'h3_ffff, 18'h0, 1'b0},
        {6'h31, 18'h1, 18'h0, 1'b1}, {6'h31, 18'h0, 18'h3_ffff, 1'b0},
        {6'h32, 18'h3_ffff, 18'h0, 1'b1}, {6'h32, 18'h0, 18'h1, 1'b0},
        {6'h33, 18'h0, 18'h1, 1'b1}, {6'h34, 18'h0, 18'h1, 1'b1},
        {6'h34, 18'h3_ffff, 18'h0, 1'b0}, {6'h35, 18'h0, 18'h2_0000, 1'b0},
        {6'h36, 18'h3_ffff, 18'h0, 1'b1}, {6'h37, 18'h0, 18'h1_ffff, 1'b0}};

    bscu_unit u_dut
    (
        .mclk_i              (mclk_i),
        .rst_i               (rst_i),
        .issue_i             (issue_i),
        .func_i              (func_i),
        .minor_i             (minor_i),
        .k_i                 (k_i),
        .y_i                 (y_i),
        .operand_i           (operand_i),
        .lower_accumulator_i (lower_accumulator_i),
        .upper_accumulator_i (upper_accumulator_i),
        .b_i                 (b_i),
        .in_active_i         (in_active_i),
        .out_active_i        (out_active_i),
        .ef_active_i         (ef_active_i),
        .skip_key_i          (skip_key_i),
        .addr_i              (addr_i),
        .wdata_i             (wdata_i),
        .wr_i                (wr_i),
        .rd_i                (rd_i),
        .rdata_o             (rdata_o),
        .busy_o              (busy_o),
        .done_o              (done_o),
        .jump_o              (jump_o),
        .skip_o              (skip_o),
        .target_o            (target_o),
        .b_we_o              (b_we_o),
        .b_o                 (b_o)
    );
    always #50 mclk_i = ~mclk_i;

    // ====
    // compare and report
    task automatic chk(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    task automatic stop_test;
        if (error_cnt == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one register cycle; a read checks the word in the next cycle
    task automatic bus(input logic w, input logic [1:0] a, input logic [17:0] d);
        @(posedge mclk_i);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 0;
        rd_i <= 0;
        #1;
        if (!w) chk(rdata_o, d);
    endtask

    // issue one instruction, count cycles to done, check outcome
    task automatic run(input logic [5:0] f, m, k, input logic [17:0] u, l, op, b,
                       input logic ej, es, input int cyc);
        int n;
        @(posedge mclk_i);
        issue_i <= 1;
        func_i <= f;
        minor_i <= m;
        k_i <= k;
        upper_accumulator_i <= u;
        lower_accumulator_i <= l;
        operand_i <= op;
        b_i <= b;
        @(posedge mclk_i);
        issue_i <= 0;
        n = 0;
        #1;
        // bounded wait, a hang shows up as a wrong count
        while (done_o !== 1'b1 && n < 200)
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        c_we = b_we_o;
        c_b = b_o;
        chk(n, cyc);
        chk(jump_o, ej);
        chk(skip_o, es);
        chk(target_o, 15'h2a5c);
    endtask

    // ====
    // main sequence
    initial
    begin
        repeat (10) @(posedge mclk_i);
        rst_i <= 0;
        @(posedge mclk_i);
        #1;
        chk({busy_o, done_o, jump_o, skip_o, b_we_o}, 0);
        bus(0, 2'h1, 18'h1f);
        bus(0, 2'h3, 18'h0);
        foreach (rows[i])
            run(rows[i][42:37], 0, 0, rows[i][36:19], rows[i][18:1], 0, 0, rows[i][0], 0, 40);
        // equal compare governs jumps 60, 62, 64, 66; a less compare then governs 61, 63, 65, 67
        run(6'h02, 0, 0, 18'h7, 18'h5, 18'h5, 0, 0, 0, 1);
        bus(0, 2'h0, 18'h0_0103);
        run(6'h30, 0, 0, 18'h1, 0, 0, 0, 1, 0, 40);
        run(6'h32, 0, 0, 18'h0, 0, 0, 0, 0, 0, 40);
        run(6'h34, 0, 0, 18'h3_ffff, 0, 0, 0, 1, 0, 40);
        run(6'h36, 0, 0, 18'h0, 0, 0, 0, 0, 0, 40);
        run(6'h03, 0, 0, 18'h7, 18'h3, 18'h5, 0, 0, 0, 1);
        run(6'h31, 0, 0, 0, 0, 0, 0, 0, 0, 40);
        run(6'h33, 0, 0, 0, 0, 0, 0, 1, 0, 40);
        run(6'h35, 0, 0, 0, 0, 0, 0, 0, 0, 40);
        run(6'h37, 0, 0, 0, 0, 0, 0, 1, 0, 40);
        // masked operand equals only after the upper mask
        run(6'h06, 0, 0, 18'hf, 18'h5, 18'h3_fff5, 0, 0, 0, 1);
        run(6'h31, 0, 0, 0, 18'h5, 0, 0, 1, 0, 40);
        run(6'h28, 6'h28, 6'h00, 0, 0, 0, 0, 0, 0, 46);
        run(6'h30, 0, 0, 18'h1, 0, 0, 0, 0, 0, 40);
        // a control write clears the stage like a non-jump would
        run(6'h02, 0, 0, 0, 18'h5, 18'h5, 0, 0, 0, 1);
        bus(1, 2'h2, 18'h1);
        run(6'h30, 0, 0, 18'h1, 0, 0, 0, 0, 0, 40);
        run(6'h38, 0, 0, 0, 0, 0, 18'h3_ffff, 1, 0, 120);
        chk({c_we, c_b}, {1'b1, 18'h3_fffe});
        run(6'h38, 0, 0, 0, 0, 0, 18'h0, 0, 0, 120);
        chk(c_we, 0);
        // channel 3 all idle skips; the selected kind of transfer active on it does not
        for (int i = 0; i < 3; i++)
        begin
            in_active_i <= 0;
            out_active_i <= 0;
            ef_active_i <= 0;
            run(6'h28, 6'(6'h11 + i), 6'h03, 0, 0, 0, 0, 0, 1, 60);
            in_active_i <= (i == 0) ? 16'h0008 : 16'h0;
            out_active_i <= (i == 1) ? 16'h0008 : 16'h0;
            ef_active_i <= (i == 2) ? 16'h0008 : 16'h0;
            run(6'h28, 6'(6'h11 + i), 6'h03, 0, 0, 0, 0, 0, 0, 46);
        end
        run(6'h28, 6'h28, 6'h04, 0, 0, 0, 0, 0, 1, 60);
        run(6'h28, 6'h28, 6'h02, 0, 0, 0, 0, 0, 0, 46);
        run(6'h28, 6'h28, 6'h20, 0, 0, 0, 0, 0, 1, 60);
        bus(1, 2'h1, 18'h0);
        bus(0, 2'h1, 18'h0);
        run(6'h28, 6'h28, 6'h04, 0, 0, 0, 0, 0, 0, 46);
        // reset in mid-jump drops the result, the stage and the mask
        run(6'h02, 0, 0, 0, 18'h5, 18'h5, 0, 0, 0, 1);
        @(posedge mclk_i);
        issue_i <= 1;
        func_i <= 6'h30;
        @(posedge mclk_i);
        issue_i <= 0;
        repeat (5) @(posedge mclk_i);
        rst_i <= 1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 0;
        @(posedge mclk_i);
        #1;
        chk({busy_o, done_o, jump_o, target_o}, 0);
        bus(0, 2'h1, 18'h1f);
        run(6'h30, 0, 0, 18'h1, 0, 0, 0, 0, 0, 40);
        stop_test;
    end

    // watchdog, well past the expected run of some 1900 cycles
    initial
    begin
        #2_000_000;
        error_cnt++;
        stop_test;
    end
endmodule
`default_nettype wire
